// ### hdl/dma_ctl_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DMA_CTL_DEFS_SVH
`define DMA_CTL_DEFS_SVH
`define REG_CONTROL 3'h0
`define REG_STATUS 3'h1
`define REG_TRANSFER_COUNT_LOW 3'h2
`define REG_TRANSFER_COUNT_HIGH 3'h3
`define REG_MEM_ADDRESS_LOW 3'h4
`define REG_MEM_ADDRESS_HIGH 3'h5
`define REG_MEM_ADDRESS_EXTENSION 3'h6
`define REG_VECTOR 3'h7
`define CR_RUN 0
`define CR_DIE 1
`define CR_TOIE 2
`define CR_TCIE 3
`define CR_IOM 4
`define CR_HBUS 5
`define CR_AECE 6
`define SR_BOW 0
`define SR_DINT 1
`define SR_TOI 2
`define SR_TCZI 3
`define TC_RESET 16'h0001
`define CR_RESET 8'h00
`define STROBE_CYCLES 2
`endif

// ### hdl/dma_ctl_pkg.sv
// Types shared by the bus handshake and count block
package dma_ctl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BUSREQ,
      ST_HIADDR,
      ST_LOADDR,
      ST_ACCESS,
      ST_FINISH
   } dma_state_e;
   typedef struct packed {
      logic sync_n;
      logic read_n;
      logic write_n;
   } mem_strobes_s;
endpackage

// ### hdl/dma_bus_handshake_and_count.sv
// Bus handshake, daisy chain, register select and transfer count of the DMA engine
//
// Summary of operation
// - Pulse low-address strobe to latch A0-A7, A16
// - Hold-off low blocks new interrupt and bus requests
// - Already asserted requests survive hold-off going low
// - Interrupt ack plus read enable drives vector
// - Pass interrupt ack on when not requesting
// - Bus grant while requesting starts a transfer
// - Pass bus grant on when not requesting
// - Memory sync asserted during each transfer
// - Memory read strobe for memory-to-peripheral
// - Memory write strobe for peripheral-to-memory
// - Direction output is high during a boot run, else follows control direction bit
// - Reply line completes register accesses and transfers
// - Block done output high at count zero
// - Boot request after reset starts a 65535-transfer peripheral-to-memory run
// - Top select low drives peripheral select low
// - Top select high addresses eight own registers
// - Sixteen-bit counter holds two's complement count
// - Counter increments after each completed transfer
// - Count zero sets status bit 3
// - Count zero interrupts if enabled and not held
// - Reset loads counter with one
// - Bus request also latches upper address byte
`timescale 1ns/1ps
`include "dma_ctl_defs.svh"
module dma_bus_handshake_and_count
   import dma_ctl_pkg::*;
#(
   parameter int STROBE_LEN = `STROBE_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic chip_select_n_i,
   input wire logic [3:0] register_select_i,
   input wire logic read_enable_n_i,
   input wire logic write_enable_n_i,
   input wire logic [7:0] data_lines_i,
   output logic [7:0] data_lines_o,
   output logic data_lines_oe_n_o,
   input wire logic reply_n_i,
   output logic reply_n_o,
   output logic reply_oe_n_o,
   input wire logic true_data_i,
   input wire logic byte_mode_i,
   input wire logic peripheral_service_request_i,
   input wire logic device_interrupt_i,
   input wire logic request_hold_off_n_i,
   input wire logic int_ack_in_n_i,
   output logic int_ack_out_n_o,
   input wire logic bus_grant_in_n_i,
   output logic bus_grant_out_n_o,
   input wire logic boot_transfer_request_i,
   output logic bus_request_n_o,
   output logic interrupt_request_n_o,
   output logic low_address_latch_strobe_n_o,
   output logic address_extension_pin_o,
   output logic memory_cycle_sync_n_o,
   output logic memory_read_strobe_n_o,
   output logic memory_write_strobe_n_o,
   output logic direction_o,
   output logic block_done_o,
   output logic peripheral_select_n_o
);

   // Strobe counter is eight bits and a zero length would never strobe
   if (STROBE_LEN < 1 || STROBE_LEN > 255) begin : g_bad_strobe_len
      $error("STROBE_LEN out of range");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] control_ff;
   logic [15:0] transfer_counter_ff;
   logic [17:0] mem_addr_ff;
   logic [7:0] vector_ff;
   logic dint_ff, toi_ff, tczi_ff;
   logic boot_ff;
   dma_state_e state_ff;
   logic [7:0] wait_ff;
   logic busreq_ff, intreq_ff, addr_lo_stb_ff, iack_out_ff, bgo_ff;
   mem_strobes_s strobes_ff;
   logic dir_ff, blk_done_ff, psel_ff, ae_ff;
   logic [7:0] dout_ff;
   logic dout_oe_n_ff, reply_oe_n_ff;
   logic we_d_ff;

   function automatic logic [7:0] bus_pol(input logic [7:0] v, input logic t);
      bus_pol = t ? v : ~v;
   endfunction

   wire logic [7:0] wdata = bus_pol(data_lines_i, true_data_i);
   wire logic own_sel = !chip_select_n_i && register_select_i[3];
   wire logic per_sel = !chip_select_n_i && !register_select_i[3];
   wire logic [2:0] ridx = register_select_i[2:0];
   wire logic wr_stb = own_sel && !write_enable_n_i && we_d_ff;
   wire logic rd_act = own_sel && !read_enable_n_i;
   wire logic running = control_ff[`CR_RUN] || boot_ff;
   wire logic iom = control_ff[`CR_IOM] || boot_ff;
   wire logic tc_zero = (transfer_counter_ff == 16'h0000);
   wire logic step_done = (state_ff == ST_FINISH) && !reply_n_i;
   wire logic [15:0] tc_next = transfer_counter_ff + 16'h0001;
   wire logic tc_hit = step_done && (tc_next == 16'h0000);
   wire logic [7:0] status_val = {running, control_ff[6:4], tczi_ff, toi_ff, dint_ff,
                                  byte_mode_i};
   wire logic want_dma = running && peripheral_service_request_i && !tc_zero;
   wire logic int_cond = (dint_ff && control_ff[`CR_DIE]) || (toi_ff && control_ff[`CR_TOIE])
                         || (tczi_ff && control_ff[`CR_TCIE]) || (device_interrupt_i
                         && control_ff[`CR_DIE]);
   wire logic iack_sel = intreq_ff && !int_ack_in_n_i;
   wire logic wait_done = (wait_ff == 8'h00);
   wire logic [17:0] addr_step = byte_mode_i ? 18'h00001 : 18'h00002;
   wire logic [17:0] addr_sum = mem_addr_ff + addr_step;
   wire logic [17:0] addr_next = control_ff[`CR_AECE] ? addr_sum
                                 : {mem_addr_ff[17:16], addr_sum[15:0]};

   logic [7:0] rd_mux;
   assign rd_mux = (ridx == `REG_CONTROL) ? control_ff
                 : (ridx == `REG_STATUS) ? status_val
                 : (ridx == `REG_TRANSFER_COUNT_LOW) ? transfer_counter_ff[7:0]
                 : (ridx == `REG_TRANSFER_COUNT_HIGH) ? transfer_counter_ff[15:8]
                 : (ridx == `REG_MEM_ADDRESS_LOW) ? mem_addr_ff[7:0]
                 : (ridx == `REG_MEM_ADDRESS_HIGH) ? mem_addr_ff[15:8]
                 : (ridx == `REG_MEM_ADDRESS_EXTENSION) ? {6'h00, mem_addr_ff[17:16]}
                 : vector_ff;

   // ---------------------------------------------------------------
   // Register writes and counter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         control_ff <= `CR_RESET;
         transfer_counter_ff <= `TC_RESET;
         mem_addr_ff <= 18'h00000;
         vector_ff <= 8'h00;
         we_d_ff <= 1'b1;
         boot_ff <= 1'b0;
      end else begin
         we_d_ff <= write_enable_n_i;
         if (boot_transfer_request_i && state_ff == ST_IDLE) begin
            boot_ff <= 1'b1;
         end else if (tc_hit) begin
            boot_ff <= 1'b0;
         end
         if (wr_stb && ridx == `REG_CONTROL) begin
            control_ff <= {1'b0, wdata[6:0]};
         end
         if (step_done) begin
            transfer_counter_ff <= tc_next;
            mem_addr_ff <= addr_next;
         end else if (wr_stb && ridx == `REG_TRANSFER_COUNT_LOW) begin
            transfer_counter_ff[7:0] <= wdata;
         end else if (wr_stb && ridx == `REG_TRANSFER_COUNT_HIGH) begin
            transfer_counter_ff[15:8] <= wdata;
         end else if (wr_stb && ridx == `REG_MEM_ADDRESS_LOW) begin
            mem_addr_ff[7:0] <= wdata;
         end else if (wr_stb && ridx == `REG_MEM_ADDRESS_HIGH) begin
            mem_addr_ff[15:8] <= wdata;
         end else if (wr_stb && ridx == `REG_MEM_ADDRESS_EXTENSION) begin
            mem_addr_ff[17:16] <= wdata[1:0];
         end
         if (!byte_mode_i) begin
            mem_addr_ff[0] <= 1'b0;
         end
         if (wr_stb && ridx == `REG_VECTOR) begin
            vector_ff <= wdata;
         end
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dint_ff <= 1'b0;
         toi_ff <= 1'b0;
         tczi_ff <= 1'b0;
      end else begin
         if (device_interrupt_i) begin
            dint_ff <= 1'b1;
         end else if (wr_stb && ridx == `REG_STATUS && !wdata[`SR_DINT]) begin
            dint_ff <= 1'b0;
         end
         if (wr_stb && ridx == `REG_STATUS && !wdata[`SR_TOI]) begin
            toi_ff <= 1'b0;
         end
         if (tc_hit) begin
            tczi_ff <= 1'b1;
         end else if (wr_stb && (ridx == `REG_TRANSFER_COUNT_LOW || ridx == `REG_TRANSFER_COUNT_HIGH)) begin
            tczi_ff <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transfer sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= ST_IDLE;
         wait_ff <= 8'h00;
      end else begin
         if (!wait_done) begin
            wait_ff <= wait_ff - 8'h01;
         end
         case (state_ff)
            ST_IDLE: begin
               if (busreq_ff) begin
                  state_ff <= ST_BUSREQ;
               end
            end
            ST_BUSREQ: begin
               if (!bus_grant_in_n_i) begin
                  state_ff <= ST_HIADDR;
               end
            end
            ST_HIADDR: begin
               state_ff <= ST_LOADDR;
               wait_ff <= 8'(STROBE_LEN);
            end
            ST_LOADDR: begin
               if (wait_done) begin
                  state_ff <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               state_ff <= ST_FINISH;
            end
            ST_FINISH: begin
               if (!reply_n_i) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   wire logic in_mem = (state_ff == ST_ACCESS) || (state_ff == ST_FINISH);
   wire logic end_xfer = step_done;
   wire logic [7:0] dma_addr_byte = (state_ff == ST_BUSREQ || state_ff == ST_IDLE)
                                    ? mem_addr_ff[15:8] : mem_addr_ff[7:0];
   wire logic dma_ae = (state_ff == ST_BUSREQ || state_ff == ST_IDLE)
                       ? mem_addr_ff[17] : mem_addr_ff[16];
   wire logic dma_drive = (state_ff != ST_IDLE);

   // ---------------------------------------------------------------
   // Requests, daisy chain and pin outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busreq_ff <= 1'b0;
         intreq_ff <= 1'b0;
         addr_lo_stb_ff <= 1'b1;
         iack_out_ff <= 1'b1;
         bgo_ff <= 1'b1;
         strobes_ff <= '{sync_n: 1'b1, read_n: 1'b1, write_n: 1'b1};
         dir_ff <= 1'b0;
         blk_done_ff <= 1'b0;
         psel_ff <= 1'b1;
         ae_ff <= 1'b0;
         dout_ff <= 8'h00;
         dout_oe_n_ff <= 1'b1;
         reply_oe_n_ff <= 1'b1;
      end else begin
         // New requests need hold-off high; live ones stay put
         if (end_xfer) begin
            busreq_ff <= 1'b0;
         end else if (!busreq_ff && want_dma && request_hold_off_n_i) begin
            busreq_ff <= 1'b1;
         end
         if (!int_cond) begin
            intreq_ff <= 1'b0;
         end else if (!intreq_ff && request_hold_off_n_i) begin
            intreq_ff <= 1'b1;
         end
         iack_out_ff <= intreq_ff ? 1'b1 : int_ack_in_n_i;
         bgo_ff <= busreq_ff ? 1'b1 : bus_grant_in_n_i;
         addr_lo_stb_ff <= !(state_ff == ST_LOADDR && !wait_done);
         strobes_ff.sync_n <= !in_mem;
         strobes_ff.read_n <= !(in_mem && !iom);
         strobes_ff.write_n <= !(in_mem && iom);
         dir_ff <= iom;
         blk_done_ff <= tc_zero || tc_hit;
         psel_ff <= !(per_sel || in_mem);
         ae_ff <= true_data_i ? dma_ae : !dma_ae;
         if (iack_sel && !read_enable_n_i) begin
            dout_ff <= bus_pol(vector_ff, true_data_i);
            dout_oe_n_ff <= 1'b0;
         end else if (rd_act) begin
            dout_ff <= bus_pol(rd_mux, true_data_i);
            dout_oe_n_ff <= 1'b0;
         end else if (dma_drive) begin
            dout_ff <= bus_pol(dma_addr_byte, true_data_i);
            dout_oe_n_ff <= 1'b0;
         end else begin
            dout_oe_n_ff <= 1'b1;
         end
         reply_oe_n_ff <= !(rd_act || (own_sel && !write_enable_n_i));
      end
   end

   assign bus_request_n_o = !busreq_ff;
   assign interrupt_request_n_o = !intreq_ff;
   assign low_address_latch_strobe_n_o = addr_lo_stb_ff;
   assign int_ack_out_n_o = iack_out_ff;
   assign bus_grant_out_n_o = bgo_ff;
   assign memory_cycle_sync_n_o = strobes_ff.sync_n;
   assign memory_read_strobe_n_o = strobes_ff.read_n;
   assign memory_write_strobe_n_o = strobes_ff.write_n;
   assign direction_o = dir_ff;
   assign block_done_o = blk_done_ff;
   assign peripheral_select_n_o = psel_ff;
   assign address_extension_pin_o = ae_ff;
   assign data_lines_o = dout_ff;
   assign data_lines_oe_n_o = dout_oe_n_ff;
   assign reply_n_o = 1'b0;
   assign reply_oe_n_o = reply_oe_n_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence grant_seen;
      state_ff == ST_BUSREQ && !bus_grant_in_n_i;
   endsequence
   sequence strobe_low;
      !low_address_latch_strobe_n_o;
   endsequence

   hold_off_blocks_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !busreq_ff && !request_hold_off_n_i |=> !busreq_ff)
      else $error("bus request rose while held off");
   hold_keeps_int_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      intreq_ff && int_cond && !request_hold_off_n_i |=> intreq_ff)
      else $error("interrupt request dropped by hold off");
   iack_pass_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !intreq_ff |=> int_ack_out_n_o == $past(int_ack_in_n_i))
      else $error("interrupt ack not passed on");
   grant_pass_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !busreq_ff |=> bus_grant_out_n_o == $past(bus_grant_in_n_i))
      else $error("bus grant not passed on");
   grant_to_strobe_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      grant_seen |-> ##[1:3] strobe_low)
      else $error("low address strobe missing after grant");
   sync_in_mem_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      state_ff == ST_ACCESS |=> !memory_cycle_sync_n_o)
      else $error("memory sync not asserted");
   dir_strobe_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !memory_write_strobe_n_o |-> direction_o && memory_read_strobe_n_o)
      else $error("write strobe with wrong direction");
   count_step_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      step_done |=> transfer_counter_ff == $past(transfer_counter_ff) + 16'h0001)
      else $error("counter did not step");
   zero_flag_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      tc_hit |=> tczi_ff ##1 block_done_o)
      else $error("count zero flag or block done missing");
   psel_low_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      per_sel |=> !peripheral_select_n_o)
      else $error("peripheral select not driven low");
   read_dir_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !memory_read_strobe_n_o |-> !direction_o && memory_write_strobe_n_o)
      else $error("read strobe with wrong direction");
   done_at_zero_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      tc_zero |=> block_done_o)
      else $error("block done low at count zero");
   own_sel_high_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      own_sel && !in_mem |=> peripheral_select_n_o)
      else $error("peripheral select low on own access");

endmodule

// ### bench/mem_reply_model.sv
// Memory-side reply responder for DMA memory cycles
`timescale 1ns/1ps
module mem_reply_model (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic memory_cycle_sync_n_i,
   input wire logic [3:0] reply_delay_i,
   output logic reply_oe_n_o
);
   logic [3:0] wait_ff;
   // ----------------------------------------
   // Reply handshake
   // ----------------------------------------
   // Reply held until sync is withdrawn, so the engine must see it first
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_ff <= 4'h0;
         reply_oe_n_o <= 1'b1;
      end else if (memory_cycle_sync_n_i) begin
         wait_ff <= 4'h0;
         reply_oe_n_o <= 1'b1;
      end else if (wait_ff >= reply_delay_i) begin
         reply_oe_n_o <= 1'b0;
      end else begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule

// ### bench/tb_top.sv
// Self-checking testbench for the DMA bus handshake and count block
`timescale 1ns/1ps
module tb_top;
   import dma_ctl_pkg::*;
   logic clk, rst_n, cs_n, re_n, we_n, tdb, bow, svc_req, dint, hold_n, iack_n, bgnt_n, boot;
   logic [3:0] sel;
   logic [7:0] din, dout, rd;
   logic [3:0] dly;
   logic dl_oe_n, rep_o, rep_oe_n, mem_oe_n, reply_line;
   logic iack_out_n, bgnt_out_n, breq_n, irq_n, las_n, ext, sync_n, mrd_n, mwr_n;
   logic dir, done, psel_n;
   int fail_count, check_count;
   // Pulled-up reply line, low when any party pulls it
   assign reply_line = (rep_oe_n & mem_oe_n) ? 1'b1 : 1'b0;
   dma_bus_handshake_and_count #(.STROBE_LEN(2)) DUT (
      .core_clk_i(clk), .reset_n_i(rst_n), .chip_select_n_i(cs_n),
      .register_select_i(sel), .read_enable_n_i(re_n), .write_enable_n_i(we_n),
      .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_n_o(dl_oe_n),
      .reply_n_i(reply_line), .reply_n_o(rep_o), .reply_oe_n_o(rep_oe_n),
      .true_data_i(tdb), .byte_mode_i(bow), .peripheral_service_request_i(svc_req),
      .device_interrupt_i(dint), .request_hold_off_n_i(hold_n),
      .int_ack_in_n_i(iack_n), .int_ack_out_n_o(iack_out_n),
      .bus_grant_in_n_i(bgnt_n), .bus_grant_out_n_o(bgnt_out_n),
      .boot_transfer_request_i(boot), .bus_request_n_o(breq_n),
      .interrupt_request_n_o(irq_n), .low_address_latch_strobe_n_o(las_n),
      .address_extension_pin_o(ext), .memory_cycle_sync_n_o(sync_n),
      .memory_read_strobe_n_o(mrd_n), .memory_write_strobe_n_o(mwr_n),
      .direction_o(dir), .block_done_o(done), .peripheral_select_n_o(psel_n));
   mem_reply_model MEM (.core_clk_i(clk), .reset_n_i(rst_n), .memory_cycle_sync_n_i(sync_n),
      .reply_delay_i(dly), .reply_oe_n_o(mem_oe_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return reply_line;
         1: return breq_n;
         2: return las_n;
         default: return sync_n;
      endcase
   endfunction
   // Bounded wait; running out is a failure
   // Sampled on the falling edge so outputs launched by the rising edge have settled
   task automatic wait_for(input int w, input logic lvl);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         if (pick(w) === lvl) return;
      end
      fail_count++;
      $display("mismatch wait %0d expected %b seen timeout", w, lvl);
      give_verdict();
   endtask
   task automatic do_reset();
      @(negedge clk);
      {cs_n, re_n, we_n, iack_n, bgnt_n, hold_n, tdb, bow} = 8'hFF;
      {svc_req, dint, boot, rst_n} = 4'h0;
      sel = 4'h0;
      din = 8'h00;
      dly = 4'h2;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
   endtask
   task automatic reg_acc(input logic wr, input logic [2:0] idx, input logic [7:0] val);
      @(negedge clk);
      cs_n = 1'b0;
      sel = {1'b1, idx};
      din = val;
      if (wr) we_n = 1'b0;
      else re_n = 1'b0;
      wait_for(0, 1'b0);
      rd = dout;
      check("peripheral select", {7'h0, psel_n}, 8'h01);
      @(negedge clk);
      {cs_n, we_n, re_n} = 3'h7;
      @(negedge clk);
   endtask
   task automatic dma_one(input logic d, input logic [17:0] a);
      @(negedge clk);
      svc_req = 1'b1;
      wait_for(1, 1'b0);
      check("strobe before grant", {7'h0, las_n}, 8'h01);
      check("upper extension", {7'h0, ext}, {7'h0, a[17]});
      @(negedge clk);
      bgnt_n = 1'b0;
      svc_req = 1'b0;
      wait_for(2, 1'b0);
      check("low address", dout, a[7:0]);
      check("low extension", {7'h0, ext}, {7'h0, a[16]});
      wait_for(3, 1'b0);
      check("read strobe", {7'h0, mrd_n}, {7'h0, d});
      check("write strobe", {7'h0, mwr_n}, {7'h0, ~d});
      check("grant out", {7'h0, bgnt_out_n}, 8'h01);
      check("direction", {7'h0, dir}, {7'h0, d});
      wait_for(1, 1'b1);
      @(negedge clk);
      bgnt_n = 1'b1;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fail_count = 0;
      check_count = 0;
      rst_n = 1'b0;
      do_reset();
      check("block done", {7'h0, done}, 8'h00);
      reg_acc(1'b0, 3'h2, 8'h00);
      check("count low", rd, 8'h01);
      reg_acc(1'b0, 3'h3, 8'h00);
      check("count high", rd, 8'h00);
      // Extension register keeps only its two low bits
      for (int i = 4; i < 8; i++) begin
         reg_acc(1'b1, i[2:0], 8'hA0 + 8'(i));
         reg_acc(1'b0, i[2:0], 8'h00);
         check("register", rd, (i == 6) ? 8'h02 : 8'hA0 + 8'(i));
      end
      @(negedge clk);
      {cs_n, sel, re_n} = {1'b0, 4'h5, 1'b0};
      repeat (2) @(negedge clk);
      check("peripheral select", {6'h0, psel_n, dl_oe_n}, 8'h01);
      {cs_n, re_n} = 2'h3;
      reg_acc(1'b1, 3'h0, 8'h10);
      check("direction", {7'h0, dir}, 8'h01);
      tdb = 1'b0;
      reg_acc(1'b0, 3'h7, 8'h00);
      check("complement read", rd, 8'h58);
      tdb = 1'b1;
      $display("test registers done");
      reg_acc(1'b1, 3'h2, 8'hFE);
      reg_acc(1'b1, 3'h3, 8'hFF);
      reg_acc(1'b1, 3'h0, 8'h09);
      dma_one(1'b0, 18'h2A5A4);
      reg_acc(1'b1, 3'h0, 8'h19);
      dly = 4'h6;
      dma_one(1'b1, 18'h2A5A5);
      repeat (2) @(negedge clk);
      check("block done", {7'h0, done}, 8'h01);
      check("interrupt", {7'h0, irq_n}, 8'h00);
      reg_acc(1'b0, 3'h1, 8'h00);
      check("count zero flag", rd, 8'h99);
      reg_acc(1'b0, 3'h2, 8'h00);
      check("count after", rd, 8'h00);
      @(negedge clk);
      {iack_n, re_n} = 2'h0;
      repeat (2) @(negedge clk);
      check("vector", dout, 8'hA7);
      check("ack out held", {6'h0, iack_out_n, dl_oe_n}, 8'h02);
      {iack_n, re_n} = 2'h3;
      $display("test transfers done");
      reg_acc(1'b1, 3'h3, 8'hFF);
      reg_acc(1'b1, 3'h0, 8'h02);
      @(negedge clk);
      {hold_n, dint} = 2'h1;
      repeat (3) @(negedge clk);
      check("held interrupt", {7'h0, irq_n}, 8'h01);
      {iack_n, bgnt_n} = 2'h0;
      repeat (2) @(negedge clk);
      check("chain out", {6'h0, iack_out_n, bgnt_out_n}, 8'h00);
      {iack_n, bgnt_n, hold_n} = 3'h7;
      repeat (3) @(negedge clk);
      check("interrupt", {7'h0, irq_n}, 8'h00);
      hold_n = 1'b0;
      repeat (3) @(negedge clk);
      check("kept interrupt", {7'h0, irq_n}, 8'h00);
      $display("test hold-off done");
      do_reset();
      boot = 1'b1;
      dma_one(1'b1, 18'h00000);
      boot = 1'b0;
      reg_acc(1'b0, 3'h2, 8'h00);
      check("boot count", rd, 8'h02);
      $display("test boot done");
      give_verdict();
   end
endmodule
